// [verilog/psa_decoder.sv]
// Sync supervision, address match, timeouts, remote programming, sysinfo readout
`timescale 1ns/10ps
`include "psa_consts.svh"
module psa_decoder import psa_pkg::*; #(
    parameter logic [39:0] MINUTE_CYCLES = 40'(`PSA_MINUTE_S) * 40'(`PSA_CLK_MHZ) * 40'd1000000,
    parameter logic [31:0] MSG_CYCLES = 32'(`PSA_MSG_TIMEOUT_S) * 32'(`PSA_CLK_MHZ) * 32'd1000000
) (
    input  wire logic         sys_clk_in,
    input  wire logic         sys_rst_in,
    input  wire psa_axi_req_t axi_req_in,
    output psa_axi_rsp_t      axi_rsp_out,
    input  wire logic         symbol_msb_in,
    input  wire logic         symbol_lsb_in,
    output logic [1:0]        symbol_out,
    output logic              filter_enhanced_out,
    input  wire logic         sync_found_in,
    input  wire logic         sync_missing_in,
    input  wire logic         home_network_in,
    input  wire logic [3:0]   current_batch_in,
    input  wire psa_addr_ev_t addr_ev_in,
    input  wire psa_word_ev_t word_ev_in,
    input  wire logic         end_delimiter_in,
    input  wire logic         cw_valid_in,
    input  wire logic [2:0]   cw_errors_in,
    output logic              cw_accept_out,
    input  wire psa_rp_ev_t   rp_ev_in,
    input  wire logic [28:0]  sysinfo_word_in,
    input  wire logic         sysinfo_clock_in,
    output logic              sysinfo_data_pin_out,
    output logic              sysinfo_data_pin_oe_out,
    output logic              sync_valid_out,
    output logic              rf_on_out,
    output logic [34:0]       matched_ric_out,
    output logic [23:0]       end_word_out,
    output logic              end_word_valid_out,
    output logic [23:0]       message_data_out,
    output logic              message_data_valid_out
);
    logic [31:0] ctrl_reg, addr1_reg, addr2_reg, operator_identity_reg, rp_addr_reg, rp_operator_identity_reg;
    psa_ctrl_t   cfg;
    psa_mode_t   mode;
    logic [39:0] hold_cnt;
    logic [39:0] hold_limit;
    logic [31:0] msg_cnt;
    logic        searching;
    logic [5:0]  ref_area;
    logic        last_epa, last_etm;
    logic        msb_s1, msb_s2, lsb_s1, lsb_s2;
    logic [1:0]  sym_hist1, sym_hist2;
    logic        sclk_s1, sclk_s2, sclk_d;
    logic        sclk_rise, sclk_fall;
    logic [4:0]  si_cnt;
    logic [28:0] si_shift;
    logic        wr_go, rd_go, bvalid_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic        match1, match2, start_search, area_bad, time_up;
    logic        in_batch, tracking;
    logic [17:0] rp_filled;
    logic [1:0]  sym_fixed;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a <= `PSA_OFF_ENDWORD) && (a[1:0] == 2'h0);
    endfunction : is_mapped

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            o[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
        end
        merge = o;
    endfunction : merge

    assign cfg = psa_ctrl_t'(ctrl_reg[10:0]);

    // Register bus: write needs address and data in the same cycle
    assign wr_go = axi_req_in.awvalid && axi_req_in.wvalid && !bvalid_q;
    assign rd_go = axi_req_in.arvalid && !rvalid_q;
    assign axi_rsp_out = {wr_go, wr_go, bvalid_q, bresp_q, rd_go, rvalid_q, rdata_q, rresp_q};

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `PSA_RESP_OK;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= is_mapped(axi_req_in.awaddr) ? `PSA_RESP_OK : `PSA_RESP_ERR;
        end else if (axi_req_in.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `PSA_RESP_OK;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q  <= is_mapped(axi_req_in.araddr) ? `PSA_RESP_OK : `PSA_RESP_ERR;
            unique case (axi_req_in.araddr)
                `PSA_OFF_CTRL:    rdata_q <= ctrl_reg;
                `PSA_OFF_ADDR1:   rdata_q <= addr1_reg;
                `PSA_OFF_ADDR2:   rdata_q <= addr2_reg;
                `PSA_OFF_OPERATOR_IDENTITY:    rdata_q <= operator_identity_reg;
                `PSA_OFF_RPADDR:  rdata_q <= rp_addr_reg;
                `PSA_OFF_RPOPID:  rdata_q <= rp_operator_identity_reg;
                `PSA_OFF_STATUS:  rdata_q <= {26'h0, last_epa, last_etm, searching,
                                              sync_valid_out, 2'(mode)};
                `PSA_OFF_ENDWORD: rdata_q <= {8'h00, end_word_out};
                default:          rdata_q <= 32'h0000_0000;
            endcase
        end else if (axi_req_in.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Option registers; all clear after reset so a fresh device matches only address 0 in batch 0
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ctrl_reg  <= `PSA_REG_RST;
            addr1_reg <= `PSA_REG_RST;
            addr2_reg <= `PSA_REG_RST;
            operator_identity_reg  <= `PSA_REG_RST;
        end else if (wr_go) begin
            unique case (axi_req_in.awaddr)
                `PSA_OFF_CTRL:  ctrl_reg  <= {21'h0, 11'(merge(ctrl_reg, axi_req_in.wdata,
                                                               axi_req_in.wstrb))};
                `PSA_OFF_ADDR1: addr1_reg <= {4'h0, 28'(merge(addr1_reg, axi_req_in.wdata,
                                                              axi_req_in.wstrb))};
                `PSA_OFF_ADDR2: addr2_reg <= {8'h00, 24'(merge(addr2_reg, axi_req_in.wdata,
                                                               axi_req_in.wstrb))};
                `PSA_OFF_OPERATOR_IDENTITY:  operator_identity_reg  <= {19'h0, 13'(merge(operator_identity_reg, axi_req_in.wdata,
                                                               axi_req_in.wstrb))};
                default: ;
            endcase
        end
    end

    // Over-the-air update wins over a software write in the same cycle
    assign rp_filled = rp_ev_in.data & ~(`PSA_RP_ONES >> rp_ev_in.len);
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rp_addr_reg <= `PSA_REG_RST;
            rp_operator_identity_reg <= `PSA_REG_RST;
        end else if (rp_ev_in.valid) begin
            unique case (rp_ev_in.field)
                2'h0:    rp_addr_reg[17:0]  <= rp_filled;
                2'h1:    rp_addr_reg[23:18] <= rp_filled[17:12];
                default: rp_operator_identity_reg[12:0]  <= rp_filled[17:5];
            endcase
        end else if (wr_go && axi_req_in.awaddr == `PSA_OFF_RPADDR) begin
            rp_addr_reg <= {8'h00, 24'(merge(rp_addr_reg, axi_req_in.wdata, axi_req_in.wstrb))};
        end else if (wr_go && axi_req_in.awaddr == `PSA_OFF_RPOPID) begin
            rp_operator_identity_reg <= {19'h0, 13'(merge(rp_operator_identity_reg, axi_req_in.wdata, axi_req_in.wstrb))};
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            message_data_valid_out <= 1'b0;
            message_data_out       <= 24'h000000;
        end else begin
            message_data_valid_out <= rp_ev_in.valid;
            if (rp_ev_in.valid) begin
                message_data_out <= {`PSA_FC_MSG, 1'b0, cfg.rp_index, rp_filled};
            end
        end
    end

    // Symbol input: pins are asynchronous, two flops before use
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            {msb_s1, msb_s2, lsb_s1, lsb_s2} <= 4'h0;
            sym_hist1 <= 2'h0;
            sym_hist2 <= 2'h0;
        end else begin
            msb_s1    <= symbol_msb_in;
            msb_s2    <= msb_s1;
            lsb_s1    <= symbol_lsb_in;
            lsb_s2    <= lsb_s1;
            sym_hist1 <= sym_fixed;
            sym_hist2 <= sym_hist1;
        end
    end
    assign sym_fixed = {msb_s2 ^ cfg.msb_input_invert, lsb_s2 ^ cfg.lsb_input_invert};

    // Enhanced mode votes over three samples; costs one cycle of latency
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            symbol_out          <= 2'h0;
            filter_enhanced_out <= 1'b0;
        end else begin
            filter_enhanced_out <= cfg.filter_select && cfg.power_select;
            if (cfg.filter_select && cfg.power_select) begin
                symbol_out <= (sym_fixed & sym_hist1) | (sym_fixed & sym_hist2)
                            | (sym_hist1 & sym_hist2);
            end else begin
                symbol_out <= sym_fixed;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            cw_accept_out <= 1'b0;
        end else begin
            cw_accept_out <= cw_valid_in && (cw_errors_in <= `PSA_MAX_ERR);
        end
    end

    // Sync supervision
    assign tracking   = (mode == PSA_LOCK) || (mode == PSA_NORMAL);
    assign hold_limit = MINUTE_CYCLES * (40'(cfg.sync_loss_hold_sel) + 40'd1);
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !tracking || !sync_missing_in) begin
            hold_cnt <= 40'h00_0000_0000;
        end else begin
            hold_cnt <= hold_cnt + 40'd1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            mode <= PSA_SCAN;
        end else begin
            unique case (mode)
                PSA_SCAN: if (sync_found_in) begin
                    mode <= PSA_SYNC;
                end
                PSA_SYNC: if (!sync_missing_in) begin
                    mode <= home_network_in ? PSA_LOCK : PSA_NORMAL;
                end
                PSA_LOCK, PSA_NORMAL: if (hold_cnt >= hold_limit) begin
                    mode <= PSA_SCAN;
                end
            endcase
        end
    end
    assign sync_valid_out = (mode == PSA_SCAN);

    // Address match and message search
    assign in_batch = current_batch_in == addr1_reg[`PSA_BATCH_LSB +: 4];
    assign match1 = addr_ev_in.addr == addr1_reg[17:0]
                 && (!cfg.primary_area_check
                     || addr_ev_in.area == addr1_reg[`PSA_AREA_LSB +: 6]);
    assign match2 = cfg.second_addr_enable && addr_ev_in.addr == addr2_reg[17:0]
                 && (!cfg.second_area_check
                     || addr_ev_in.area == addr2_reg[`PSA_AREA_LSB +: 6]);
    // A matching sub-message of a long message restarts the timer
    assign start_search = addr_ev_in.valid && tracking && in_batch && (match1 || match2);
    assign area_bad = searching && word_ev_in.valid && word_ev_in.area != ref_area;
    assign time_up  = searching && msg_cnt >= MSG_CYCLES;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || start_search || !searching) begin
            msg_cnt <= 32'h0000_0000;
        end else begin
            msg_cnt <= msg_cnt + 32'd1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            searching       <= 1'b0;
            ref_area        <= 6'h00;
            matched_ric_out <= 35'h0_0000_0000;
        end else if (start_search) begin
            searching       <= 1'b1;
            ref_area        <= addr_ev_in.area;
            matched_ric_out <= {operator_identity_reg[2:0], operator_identity_reg[`PSA_COUNTRY_LSB +: 7],
                                operator_identity_reg[`PSA_OPER_LSB +: 3], addr_ev_in.addr,
                                addr1_reg[`PSA_BATCH_LSB +: 4]};
        end else if (area_bad || time_up || end_delimiter_in || !tracking) begin
            searching <= 1'b0;
        end
    end

    // Area change is checked first when both fire together
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            end_word_valid_out <= 1'b0;
            end_word_out       <= 24'h000000;
            last_epa           <= 1'b0;
            last_etm           <= 1'b0;
        end else begin
            end_word_valid_out <= searching && !start_search
                                  && (area_bad || time_up || end_delimiter_in);
            if (searching && !start_search && (area_bad || time_up || end_delimiter_in)) begin
                last_epa     <= area_bad;
                last_etm     <= time_up && !area_bad;
                end_word_out <= {`PSA_FC_END, area_bad, time_up && !area_bad, 18'h00000};
            end
        end
    end

    // Receiver stays on while scanning and syncing; a message may overrun its batch
    assign rf_on_out = !tracking
                    || ((in_batch || searching) && !end_delimiter_in);

    // Sysinfo readout, host clock sampled and edge-detected here
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            {sclk_s1, sclk_s2, sclk_d} <= 3'h0;
        end else begin
            sclk_s1 <= sysinfo_clock_in;
            sclk_s2 <= sclk_s1;
            sclk_d  <= sclk_s2;
        end
    end
    assign sclk_rise = sclk_s2 && !sclk_d;
    assign sclk_fall = !sclk_s2 && sclk_d;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !cfg.sysinfo_read_enable) begin
            si_cnt                  <= 5'h00;
            sysinfo_data_pin_oe_out <= 1'b0;
        end else if (sclk_rise && si_cnt == `PSA_SI_LAST) begin
            si_cnt                  <= 5'h00;
            sysinfo_data_pin_oe_out <= 1'b0;
        end else if (sclk_rise && si_cnt == 5'h00) begin
            si_cnt                  <= 5'h01;
            sysinfo_data_pin_oe_out <= 1'b1;
        end else if (sclk_rise) begin
            si_cnt <= si_cnt + 5'h01;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            si_shift             <= 29'h0000_0000;
            sysinfo_data_pin_out <= 1'b0;
        end else if (sclk_rise && si_cnt == 5'h00) begin
            si_shift <= sysinfo_word_in;
        end else if (sclk_fall && sysinfo_data_pin_oe_out && si_cnt >= 5'h02) begin
            sysinfo_data_pin_out <= si_shift[`PSA_SI_BITS - 1];
            si_shift             <= {si_shift[27:0], 1'b0};
        end
    end

    property p_sync_low;
        mode != PSA_SCAN |-> !sync_valid_out;
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("sync valid high outside scan");

    property p_hold_exit;
        tracking && hold_cnt >= hold_limit |=> mode == PSA_SCAN && sync_valid_out;
    endproperty
    a_hold_exit: assert property (p_hold_exit) else $error("hold expiry not honoured");

    property p_hold_limit;
        hold_limit == MINUTE_CYCLES * (40'(cfg.sync_loss_hold_sel) + 40'd1);
    endproperty
    a_hold_limit: assert property (p_hold_limit) else $error("wrong hold limit");

    property p_invert;
        !(cfg.filter_select && cfg.power_select) ##1 !(cfg.filter_select && cfg.power_select)
        |-> symbol_out == ({$past(msb_s2), $past(lsb_s2)}
                           ^ {$past(cfg.msb_input_invert), $past(cfg.lsb_input_invert)});
    endproperty
    a_invert: assert property (p_invert) else $error("symbol inversion wrong");

    property p_cw;
        cw_valid_in && cw_errors_in > `PSA_MAX_ERR |=> !cw_accept_out;
    endproperty
    a_cw: assert property (p_cw) else $error("codeword with too many errors accepted");

    property p_rp_zero;
        rp_ev_in.valid |=> message_data_valid_out
            && (message_data_out[17:0] & (`PSA_RP_ONES >> $past(rp_ev_in.len))) == 18'h00000;
    endproperty
    a_rp_zero: assert property (p_rp_zero) else $error("programming data not zero-filled");

    property p_epa;
        searching && !start_search && area_bad |=> end_word_valid_out
            && end_word_out[`PSA_EW_EPA] && !searching;
    endproperty
    a_epa: assert property (p_epa) else $error("area change did not end search");

    property p_etm;
        searching && !start_search && time_up && !area_bad |=> end_word_out[`PSA_EW_ETM];
    endproperty
    a_etm: assert property (p_etm) else $error("timeout flag missing");

    property p_delim;
        tracking && end_delimiter_in |-> !rf_on_out;
    endproperty
    a_delim: assert property (p_delim) else $error("receiver on at end delimiter");

    property p_fc;
        end_word_valid_out |-> end_word_out[23:20] == `PSA_FC_END;
    endproperty
    a_fc: assert property (p_fc) else $error("end word function code wrong");

    property p_si_idle;
        si_cnt == 5'h00 |-> !sysinfo_data_pin_oe_out;
    endproperty
    a_si_idle: assert property (p_si_idle) else $error("sysinfo pin driven while idle");

    property p_si_last;
        sclk_rise && si_cnt == `PSA_SI_LAST |=> !sysinfo_data_pin_oe_out ##1 si_cnt == 5'h00;
    endproperty
    a_si_last: assert property (p_si_last) else $error("last pulse did not end readout");

    property p_batch;
        tracking && rf_on_out |-> in_batch || searching;
    endproperty
    a_batch: assert property (p_batch) else $error("receiver on outside own batch");

    c_epa_end:  cover property (searching ##1 end_word_valid_out && last_epa);
    c_etm_end:  cover property (searching ##1 end_word_valid_out && last_etm);
    c_sync_out: cover property (tracking ##1 mode == PSA_SCAN);
    c_si_done:  cover property (sclk_rise && si_cnt == `PSA_SI_LAST);
    c_rp:       cover property (rp_ev_in.valid && rp_ev_in.len < 5'h12);
endmodule : psa_decoder

// [verilog/psa_consts.svh]
// Constants for the pager sync, address and timeout block
// Summary of operation
// - Two-bit select gives one to four minutes
// - Sync valid low; high and scan on timeout
// - Identity code is zone, country, operator, address, batch
// - Two addresses; second only when enabled
// - Listen only in own batch, overrun allowed
// - Primary area check or consistent area
// - Same area rule for second address
// - Remote programming updates temporaries, forwards message
// - Short programming data zero-filled in low bits
// - Sysinfo readout only while its enable set
// - 31 pulses: first turns pin, last ends
// - Next sysinfo bit on each middle falling edge
// - Symbol bits each optionally inverted
// - Filter and power bits select filtering
// - Accept codewords with at most two errors
// - Search stops at timeout, flags in end word
// - Receiver control drops at end delimiter
// - Area change or twelve seconds ends search
// - Each long sub-message timed like individual
// - Sync mode drives sync valid low
// - End word carries function code 1110
`ifndef PSA_CONSTS_SVH
`define PSA_CONSTS_SVH
`define PSA_CLK_MHZ       250
`define PSA_MINUTE_S      60
`define PSA_MSG_TIMEOUT_S 12
`define PSA_OFF_CTRL      8'h00
`define PSA_OFF_ADDR1     8'h04
`define PSA_OFF_ADDR2     8'h08
`define PSA_OFF_OPERATOR_IDENTITY      8'h0C
`define PSA_OFF_RPADDR    8'h10
`define PSA_OFF_RPOPID    8'h14
`define PSA_OFF_STATUS    8'h18
`define PSA_OFF_ENDWORD   8'h1C
`define PSA_AREA_LSB      18
`define PSA_BATCH_LSB     24
`define PSA_COUNTRY_LSB   3
`define PSA_OPER_LSB      10
`define PSA_EW_EPA        19
`define PSA_EW_ETM        18
`define PSA_REG_RST       32'h0000_0000
`define PSA_FC_END        4'hE
`define PSA_FC_MSG        4'h6
`define PSA_SI_LAST       5'h1E
`define PSA_SI_BITS       29
`define PSA_MAX_ERR       3'h2
`define PSA_RP_ONES       18'h3FFFF
`define PSA_RESP_OK       2'h0
`define PSA_RESP_ERR      2'h2
`endif

// [verilog/psa_pkg.sv]
// Types for the pager sync, address and timeout block
package psa_pkg;
    typedef enum logic [1:0] {PSA_SCAN, PSA_SYNC, PSA_LOCK, PSA_NORMAL} psa_mode_t;
    typedef struct packed {
        logic       rp_index;
        logic       power_select;
        logic       filter_select;
        logic       lsb_input_invert;
        logic       msb_input_invert;
        logic       sysinfo_read_enable;
        logic       second_area_check;
        logic       primary_area_check;
        logic       second_addr_enable;
        logic [1:0] sync_loss_hold_sel;
    } psa_ctrl_t;
    typedef struct packed {
        logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
        logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
    } psa_axi_req_t;
    typedef struct packed {
        logic awready; logic wready; logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } psa_axi_rsp_t;
    typedef struct packed {logic valid; logic [17:0] addr; logic [5:0] area;} psa_addr_ev_t;
    typedef struct packed {logic valid; logic [5:0] area;} psa_word_ev_t;
    typedef struct packed {
        logic valid; logic [1:0] field; logic [4:0] len; logic [17:0] data;
    } psa_rp_ev_t;
endpackage : psa_pkg

// [verification/psa_host_model.sv]
// Host model: clocks the sysinfo readout and gathers the shifted bits
`timescale 1ns/10ps
module psa_host_model (
    input  wire logic   start_in,
    input  wire logic   pin_in,
    output logic        clk_out,
    output logic [28:0] bits_out
);
    initial begin
        clk_out = 1'b0;
        @(posedge start_in);
        for (int i = 0; i < 31; i++) begin
            if (i > 1) bits_out = {bits_out[27:0], pin_in};
            clk_out = 1'b1;
            #40 clk_out = 1'b0;
            #40;
        end
    end
endmodule : psa_host_model

// [verification/tb_top.sv]
// Self-checking bench for the pager sync, address and timeout block
`timescale 1ns/10ps
module tb_top import psa_pkg::*;;
    logic         sys_clk_in, sys_rst_in, msb, lsb, found, miss, start, hclk, oe, pin;
    logic         dlm, cwv, acc, rf, fe;
    logic [1:0]   sym;
    logic [2:0]   cwe;
    logic [34:0]  ric;
    logic [3:0]   bat;
    psa_axi_req_t rq;
    psa_axi_rsp_t rs;
    psa_addr_ev_t aev;
    psa_word_ev_t wev;
    psa_rp_ev_t   rpe;
    int           n_mismatch, cmp_count;
    psa_decoder #(.MINUTE_CYCLES(40'd50), .MSG_CYCLES(32'd200)) uut (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .axi_req_in(rq), .axi_rsp_out(rs),
        .symbol_msb_in(msb), .symbol_lsb_in(lsb), .symbol_out(sym), .filter_enhanced_out(fe),
        .sync_found_in(found), .sync_missing_in(miss), .home_network_in(1'b1), .rp_ev_in(rpe),
        .current_batch_in(bat), .addr_ev_in(aev), .word_ev_in(wev), .end_delimiter_in(dlm),
        .cw_valid_in(cwv), .cw_errors_in(cwe), .cw_accept_out(acc), .sysinfo_clock_in(hclk),
        .sysinfo_word_in(29'h0ABCDEF5), .sysinfo_data_pin_out(pin), .sysinfo_data_pin_oe_out(oe),
        .sync_valid_out(), .rf_on_out(rf), .matched_ric_out(ric), .end_word_out(),
        .end_word_valid_out(), .message_data_out(), .message_data_valid_out());
    psa_host_model host (.start_in(start), .pin_in(oe ? pin : ~pin), .clk_out(hclk), .bits_out());
    task automatic chk(input string nm, input logic [34:0] e, s);
        cmp_count++;
        n_mismatch += 32'(s !== e);
        if (s !== e) $display("[FAIL] %s expected %h seen %h", nm, e, s);
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_in);
    endtask : tick
    task automatic bus(input logic w, logic [7:0] a, logic [31:0] d, logic [1:0] r);
        {rq.awvalid, rq.wvalid, rq.arvalid} <= {w, w, !w};
        {rq.awaddr, rq.araddr, rq.wdata} <= {a, a, d};
        do tick(1); while (!(w ? rs.awready && rs.wready : rs.arready));
        {rq.awvalid, rq.wvalid, rq.arvalid, rq.bready, rq.rready} <= {3'b000, w, !w};
        do tick(1); while (!(w ? rs.bvalid : rs.rvalid));
        {rq.bready, rq.rready} <= 2'b00;
        chk("resp_data", {r, w ? 32'h0 : d}, {w ? rs.bresp : rs.rresp, w ? 32'h0 : rs.rdata});
    endtask : bus
    task automatic close_out(input int hang);
        n_mismatch += hang;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    initial forever #2 sys_clk_in = ~sys_clk_in;
    initial #60000 close_out(1);
    initial begin
        {sys_clk_in, msb, lsb, found, miss, start, bat, sys_rst_in} = 11'h007;
        {rq, aev, wev, rpe, dlm, cwv, cwe} = '0;
        rq.wstrb = 4'hF;
        tick(12);
        sys_rst_in <= 1'b0;
        tick(1);
        chk("sync_valid", 1'b1, uut.sync_valid_out);
        bus(1'b1, 8'h00, 32'h0000_0000, 2'h0);
        bus(1'b1, 8'h00, 32'h0000_006C, 2'h0);
        bus(1'b1, 8'h04, 32'h0315_2345, 2'h0);
        bus(1'b1, 8'h08, 32'h0024_0ABC, 2'h0);
        bus(1'b1, 8'h0C, 32'h0000_150A, 2'h0);
        bus(1'b0, 8'h04, 32'h0315_2345, 2'h0);
        bus(1'b0, 8'h20, 32'h0000_0000, 2'h2);
        {msb, lsb} <= 2'b01;
        tick(4);
        chk("symbol", 2'b11, sym);
        chk("filter", 1'b0, fe);
        cwv <= 1'b1;
        cwe <= 3'h2;
        tick(1);
        cwe <= 3'h3;
        tick(1);
        chk("cw_accept", 1'b1, acc);
        cwv <= 1'b0;
        tick(1);
        chk("cw_accept", 1'b0, acc);
        bus(1'b1, 8'h00, 32'h0000_03EC, 2'h0);
        tick(3);
        chk("symbol", 2'b10, sym);
        chk("filter", 1'b1, fe);
        $display("test registers done");
        found <= 1'b1;
        tick(1);
        found <= 1'b0;
        tick(4);
        chk("sync_valid", 1'b0, uut.sync_valid_out);
        for (int i = 0; i < 3; i++) begin
            aev <= {1'b1, (i == 2) ? 18'h00ABC : 18'h12345, (i == 2) ? 6'h11 : 6'h05};
            tick(1);
            {aev.valid, wev, dlm} <= {1'b0, i == 0, 6'h07, i == 2};
            tick(1);
            if (i == 2) chk("rf_on", 1'b0, rf);
            {wev.valid, dlm} <= 2'b00;
            do tick(1); while (uut.end_word_valid_out !== 1'b1);
            chk("end_word", {4'hE, i == 0, i == 1, 18'h00000}, uut.end_word_out);
            chk("ric", {3'h2, 7'h21, 3'h5, (i == 2) ? 18'h00ABC : 18'h12345, 4'h3}, ric);
        end
        rpe <= {1'b1, 2'h0, 5'd4, 18'h3FFFF};
        tick(1);
        rpe.valid <= 1'b0;
        do tick(1); while (uut.message_data_valid_out !== 1'b1);
        chk("msg_data", 24'h63_C000, uut.message_data_out);
        bus(1'b0, 8'h10, 32'h0003_C000, 2'h0);
        $display("test messages done");
        bat <= 4'h4;
        tick(1);
        chk("rf_on", 1'b0, rf);
        start <= 1'b1;
        wait (oe === 1'b1);
        wait (oe === 1'b0);
        tick(1);
        chk("sysinfo", 29'h0ABCDEF5, host.bits_out);
        miss <= 1'b1;
        tick(40);
        chk("sync_valid", 1'b0, uut.sync_valid_out);
        tick(20);
        chk("sync_valid", 1'b1, uut.sync_valid_out);
        $display("test sysinfo and sync loss done");
        close_out(0);
    end
endmodule : tb_top
